// ==== logic/test_mode_serial_config.sv ====
// Test-mode sequencer and serial configuration loader
module test_mode_serial_config #(
    parameter int STANDBY_CYC = tmcfg_pkg::STANDBY_LOW_CYC
) (
    input  wire logic                  CLK_SYS,
    input  wire logic                  RST,
    input  wire logic                  MODE_STEP_PIN,
    input  wire logic                  MODE_DATA_PIN,
    input  wire logic                  SHIFT_CLK_PIN,
    input  wire logic                  COMMIT_STROBE_PIN,
    input  tmcfg_pkg::check_in_t       CHECK_IN,
    input  tmcfg_pkg::config_word_t    NVM_READ_WORD,
    output logic                       CHECK_RESULT_OUT,
    output logic                       INDICATOR_LAMP_OUT,
    output logic                       SOUNDER_OUT,
    output logic                       BATTERY_TEST_EN,
    output logic                       NVM_WRITE,
    output tmcfg_pkg::config_word_t    NVM_WRITE_WORD,
    output logic                       READBACK_OUT,
    output logic                       SERIAL_MODE,
    output logic [5:0]                 TEST_MODE
);
    import tmcfg_pkg::*;

    logic       step_lvl;
    logic       step_rise;
    logic       step_fall;
    logic       data_lvl;
    logic       data_rise;
    logic       data_fall;
    logic       sclk_lvl;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       strb_lvl;
    logic       strb_rise;
    logic       strb_fall;
    logic [4:0] chk_meta_reg;
    check_in_t  chk_reg;

    seq_state_t             state_reg;
    logic [5:0]             mode_reg;
    logic [WORD_BITS-1:0]   shift_reg;
    logic [5:0]             bit_cnt_reg;
    logic [WORD_BITS-1:0]   readback_reg;
    logic [5:0]             rd_cnt_reg;
    logic [$clog2(STANDBY_CYC+1)-1:0] low_cnt_reg;
    logic                   pending_reg;

    // Every pin comes through two flops before use
    tmcfg_sync u_step (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .din     (MODE_STEP_PIN),
        .level   (step_lvl),
        .rise    (step_rise),
        .fall    (step_fall)
    );
    tmcfg_sync u_data (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .din     (MODE_DATA_PIN),
        .level   (data_lvl),
        .rise    (data_rise),
        .fall    (data_fall)
    );
    tmcfg_sync u_sclk (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .din     (SHIFT_CLK_PIN),
        .level   (sclk_lvl),
        .rise    (sclk_rise),
        .fall    (sclk_fall)
    );
    tmcfg_sync u_strb (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .din     (COMMIT_STROBE_PIN),
        .level   (strb_lvl),
        .rise    (strb_rise),
        .fall    (strb_fall)
    );

    // Analog comparator outputs are asynchronous too
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            chk_meta_reg <= 5'h00;
            chk_reg      <= '0;
        end else begin
            chk_meta_reg <= CHECK_IN;
            chk_reg      <= chk_meta_reg;
        end
    end

    // Entry sequence: step high from normal enters idle, data high arms counting
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_reg <= SEQ_NORMAL;
            mode_reg  <= COUNT_RESET;
        end else begin
            case (state_reg)
                SEQ_NORMAL: begin
                    if (step_rise) begin
                        state_reg <= SEQ_IDLE;
                    end
                end
                SEQ_IDLE: begin
                    if (data_lvl) begin
                        state_reg <= SEQ_ARMED;
                    end
                end
                SEQ_ARMED: begin
                    // Count on return high; saturate so a runaway tester cannot wrap
                    if (step_rise && mode_reg != MODE_MAX) begin
                        mode_reg <= mode_reg + 6'h01;
                    end
                end
                default: begin
                    state_reg <= SEQ_NORMAL;
                end
            endcase
        end
    end

    // Serial shift in; clock edges ignored outside mode eighteen
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            shift_reg   <= WORD_RESET;
            bit_cnt_reg <= 6'h00;
        end else if (mode_reg == MODE_SERIAL && sclk_rise) begin
            // First bit in ends at bit 1 after 35 shifts: LSB-first order
            shift_reg <= {data_lvl, shift_reg[WORD_BITS-1:1]};
            if (bit_cnt_reg != 6'(WORD_BITS)) begin
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
            end
        end
    end

    // Read back the stored word on falling shift edges, LSB first
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            readback_reg <= WORD_RESET;
            rd_cnt_reg   <= 6'h00;
            READBACK_OUT <= 1'b0;
        end else if (mode_reg != MODE_SERIAL) begin
            readback_reg <= NVM_READ_WORD;
            rd_cnt_reg   <= 6'h00;
            READBACK_OUT <= 1'b0;
        end else if (sclk_fall && rd_cnt_reg != 6'(WORD_BITS)) begin
            // Bit 18 goes out as whatever memory holds; it has no meaning
            READBACK_OUT <= readback_reg[0];
            readback_reg <= {1'b0, readback_reg[WORD_BITS-1:1]};
            rd_cnt_reg   <= rd_cnt_reg + 6'h01;
        end
    end

    // Commit after a full word; a short word is not written
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            NVM_WRITE      <= 1'b0;
            NVM_WRITE_WORD <= '0;
        end else begin
            NVM_WRITE <= 1'b0;
            if (mode_reg == MODE_SERIAL && strb_rise && bit_cnt_reg == 6'(WORD_BITS)) begin
                NVM_WRITE      <= 1'b1;
                // Field layout follows the packed struct bit for bit
                NVM_WRITE_WORD <= config_word_t'(shift_reg);
            end
        end
    end
    // Feature fields are carried unchanged to memory

    // Standby check needs data low held the full minimum time
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            low_cnt_reg <= '0;
        end else if (mode_reg != MODE_STANDBY || data_lvl) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg != STANDBY_CYC[$bits(low_cnt_reg)-1:0]) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end

    // Pulse on data pin latches a check request in modes 13 to 15
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pending_reg <= 1'b0;
        end else if (mode_reg < MODE_HYST || mode_reg > MODE_BIAS) begin
            pending_reg <= 1'b0;
        end else if (data_fall || data_rise) begin
            pending_reg <= 1'b1;
        end
    end

    // Check result output, one source per test mode
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            CHECK_RESULT_OUT <= 1'b0;
        end else begin
            case (mode_reg)
                MODE_STANDBY: CHECK_RESULT_OUT <=
                    (low_cnt_reg == STANDBY_CYC[$bits(low_cnt_reg)-1:0])
                    & chk_reg.standby_smoke;
                MODE_HYST:    CHECK_RESULT_OUT <= pending_reg & chk_reg.hyst_ok;
                MODE_QUIET:   CHECK_RESULT_OUT <= pending_reg & chk_reg.quiet_ok;
                MODE_BIAS:    CHECK_RESULT_OUT <= pending_reg & chk_reg.bias_ok;
                MODE_BATTERY: CHECK_RESULT_OUT <= BATTERY_TEST_EN & chk_reg.low_battery;
                default:      CHECK_RESULT_OUT <= 1'b0;
            endcase
        end
    end

    // Sounder latches on in mode three until reset; audibility tests run long
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SOUNDER_OUT <= 1'b0;
        end else if (mode_reg == MODE_SOUNDER && data_fall) begin
            SOUNDER_OUT <= 1'b1;
        end
    end

    // Battery test and lamp follow the strobe's rise in mode seventeen
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            BATTERY_TEST_EN    <= 1'b0;
            INDICATOR_LAMP_OUT <= 1'b0;
        end else if (mode_reg != MODE_BATTERY) begin
            BATTERY_TEST_EN    <= 1'b0;
            INDICATOR_LAMP_OUT <= 1'b0;
        end else if (strb_rise) begin
            BATTERY_TEST_EN    <= 1'b1;
            INDICATOR_LAMP_OUT <= 1'b1;
        end
    end

    // Mode status outputs
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SERIAL_MODE <= 1'b0;
            TEST_MODE   <= COUNT_RESET;
        end else begin
            SERIAL_MODE <= (mode_reg == MODE_SERIAL);
            TEST_MODE   <= mode_reg;
        end
    end
endmodule : test_mode_serial_config

// ==== logic/tmcfg_pkg.sv ====
// Constants and types for the test-mode sequencer and serial configuration loader
// Summary of operation
// - Step pin high enters idle; pulses count modes
// - Mode eighteen enables serial configuration write and read
// - Data pin is bit value, shift clock shifts
// - Commit strobe after 35 bits stores to memory
// - Calibration fields sit at bits 35 to 19
// - Bit 18 unimplemented, read-back undefined
// - Bits 15 to 12 are feature enables
// - Bits 11 to 9 enable quiet and memory indications
// - Memory timeout field selects four timeouts
// - Bit 6 memory enable, bit 5 quiet timeout
// - Bit 4 lets smoke cancel quiet
// - Bit 3 restricts quiet start to local smoke
// - Bit 2 is active-low quiet disable
// - Bit 1 selects continuous or temporal tone
// - Standby check reports smoke after 1 ms data low
// - Modes 13 to 15 report checks on data pulse
// - Sounder check mode turns sounder on indefinitely
// - Battery check mode strobe enables test and lamp
package tmcfg_pkg;
    localparam int WORD_BITS          = 35;
    localparam int FEATURE_BITS       = 18;
    localparam int CAL_BITS           = 17;
    localparam logic [5:0] MODE_SOUNDER   = 6'h03;
    localparam logic [5:0] MODE_STANDBY   = 6'h0C;
    localparam logic [5:0] MODE_HYST      = 6'h0D;
    localparam logic [5:0] MODE_QUIET     = 6'h0E;
    localparam logic [5:0] MODE_BIAS      = 6'h0F;
    localparam logic [5:0] MODE_BATTERY   = 6'h11;
    localparam logic [5:0] MODE_SERIAL    = 6'h12;
    localparam logic [5:0] MODE_LOCK      = 6'h13;
    localparam logic [5:0] MODE_MAX       = 6'h3F;
    localparam logic [5:0] COUNT_RESET    = 6'h00;
    localparam int CLK_HZ             = 40_000_000;
    localparam int STANDBY_LOW_US     = 1000;
    localparam int STANDBY_LOW_CYC    = (CLK_HZ / 1_000_000) * STANDBY_LOW_US;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 35'h0_0000_0000;

    // Combined word, register bit n (1-based) at packed index n-1
    typedef struct packed {
        logic [4:0] chamber_bias_field;
        logic [3:0] quiet_sensitivity_field;
        logic [2:0] hysteresis_field;
        logic [4:0] standby_sensitivity_field;
        logic       unimplemented;
        logic [1:0] battery_trip_field;
        logic       lifetime_indicator_en;
        logic       gas_alarm_en;
        logic       alarm_locate_off;
        logic       sounder_sync_en;
        logic       battery_quiet_en;
        logic       memory_chirp_en;
        logic       memory_flash_en;
        logic [1:0] memory_timeout_sel;
        logic       alarm_memory_en;
        logic       short_quiet_sel;
        logic       adaptive_quiet_en;
        logic       quiet_in_alarm_only;
        logic       quiet_disable_n;
        logic       tone_pattern_sel;
    } config_word_t;

    // Analog check results from the detector front end
    typedef struct packed {
        logic standby_smoke;
        logic hyst_ok;
        logic quiet_ok;
        logic bias_ok;
        logic low_battery;
    } check_in_t;

    typedef enum logic [1:0] {
        SEQ_NORMAL,
        SEQ_IDLE,
        SEQ_ARMED
    } seq_state_t;
endpackage : tmcfg_pkg

// ==== logic/tmcfg_sync.sv ====
// Two-flop synchroniser with rising and falling edge detect
module tmcfg_sync (
    input  wire logic CLK_SYS,
    input  wire logic RST,
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // First flop feeds only the second
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= din;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~prev_reg;
    assign fall  = ~sync_reg & prev_reg;
endmodule : tmcfg_sync

// ==== sim/tmcfg_monitor.sv ====
// Port-level checks on the test-mode sequencer and serial loader
module tmcfg_monitor #(
    parameter int STANDBY_CYC = 20
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic              MODE_DATA_PIN,
    input  wire logic              CHECK_RESULT_OUT,
    input  wire logic              INDICATOR_LAMP_OUT,
    input  wire logic              SOUNDER_OUT,
    input  wire logic              BATTERY_TEST_EN,
    input  wire logic              NVM_WRITE,
    input  tmcfg_pkg::config_word_t NVM_WRITE_WORD,
    input  wire logic              SERIAL_MODE,
    input  wire logic [5:0]        TEST_MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    import tmcfg_pkg::*;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    int low_cnt;
    // Raw low time of the data pin; the design sees it later, so never less
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST || MODE_DATA_PIN) begin
            low_cnt <= 0;
        end else if (low_cnt < 1000000) begin
            low_cnt <= low_cnt + 1;
        end
    end
    sequence s_one_write;
        NVM_WRITE ##1 !NVM_WRITE;
    endsequence
    a_write_one_cycle: assert property (NVM_WRITE |-> s_one_write)
        else $error("write pulse too long");
    a_write_in_serial: assert property (NVM_WRITE |-> SERIAL_MODE)
        else $error("write outside serial mode");
    a_word_held: assert property (!NVM_WRITE |-> $stable(NVM_WRITE_WORD))
        else $error("write word moved without write");
    a_mode_by_one: assert property (TEST_MODE != $past(TEST_MODE) |->
        TEST_MODE == $past(TEST_MODE) + 6'h01) else $error("mode jumped");
    a_serial_entry: assert property ($rose(SERIAL_MODE) |->
        ##[0:1] TEST_MODE == MODE_SERIAL) else $error("serial mode in wrong mode");
    a_sounder_sticky: assert property (SOUNDER_OUT |=> SOUNDER_OUT)
        else $error("sounder dropped");
    a_sounder_mode: assert property ($rose(SOUNDER_OUT) |-> TEST_MODE == MODE_SOUNDER)
        else $error("sounder on in wrong mode");
    a_lamp_mode: assert property ($rose(INDICATOR_LAMP_OUT) |->
        TEST_MODE == MODE_BATTERY && BATTERY_TEST_EN) else $error("lamp in wrong mode");
    a_standby_wait: assert property ($rose(CHECK_RESULT_OUT) &&
        TEST_MODE == MODE_STANDBY |-> low_cnt >= STANDBY_CYC) else $error("standby early");
endmodule : tmcfg_monitor

bind test_mode_serial_config tmcfg_monitor #(.STANDBY_CYC(STANDBY_CYC)) u_mon (
    .CLK_SYS(CLK_SYS), .RST(RST), .MODE_DATA_PIN(MODE_DATA_PIN),
    .CHECK_RESULT_OUT(CHECK_RESULT_OUT), .INDICATOR_LAMP_OUT(INDICATOR_LAMP_OUT),
    .SOUNDER_OUT(SOUNDER_OUT), .BATTERY_TEST_EN(BATTERY_TEST_EN),
    .NVM_WRITE(NVM_WRITE), .NVM_WRITE_WORD(NVM_WRITE_WORD),
    .SERIAL_MODE(SERIAL_MODE), .TEST_MODE(TEST_MODE));

// ==== sim/tmcfg_tester.sv ====
// Tester model driving the mode, data, shift and strobe pins
module tmcfg_tester (
    input  wire logic CLK_SYS,
    input  wire logic rb_in,
    output logic      step,
    output logic      data,
    output logic      sclk,
    output logic      strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [34:0] rb_bits;
    // Wait n cycles and land just after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
        #2;
    endtask : tick
    // Power-up bias: all pins low
    task automatic idle_pins();
        step = 1'b0;
        data = 1'b0;
        sclk = 1'b0;
        strobe = 1'b0;
    endtask : idle_pins
    initial idle_pins();
    // One high-low-high step pulse per mode
    task automatic steps(input int n);
        repeat (n) begin
            step = 1'b0;
            tick(6);
            step = 1'b1;
            tick(8);
        end
    endtask : steps
    // Step high enters idle, data high arms counting
    task automatic enter_mode(input int n);
        step = 1'b1;
        tick(6);
        data = 1'b1;
        tick(6);
        steps(n);
    endtask : enter_mode
    task automatic set_data(input logic v);
        data = v;
        tick(6);
    endtask : set_data
    // Shift clock runs only in frames, 8 cycles a bit; readback taken before next rise
    task automatic shift(input logic [34:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            data = w[i];
            tick(2);
            if (i > 0) rb_bits[i-1] = rb_in;
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
            tick(2);
        end
        tick(4);
        rb_bits[n-1] = rb_in;
    endtask : shift
    task automatic strobe_pulse();
        strobe = 1'b1;
        tick(6);
        strobe = 1'b0;
        tick(4);
    endtask : strobe_pulse
endmodule : tmcfg_tester

// ==== sim/test_mode_serial_config_tb.sv ====
// Self-checking bench for the test-mode sequencer and serial loader
module test_mode_serial_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tmcfg_pkg::*;
    localparam int SB_CYC = 20;
    localparam logic [34:0] WR_WORD = 35'h5_A3C9_6E1B;
    localparam logic [34:0] RB_WORD = 35'h2_9D47_B0C6;
    localparam logic [34:0] MASK = 35'h7_FFFD_FFFF; // bit 18 undefined
    logic         clk, rst, step, data, sclk, strobe;
    logic         result, lamp, sounder, bat_en, nvm_wr, rb, serial;
    logic [5:0]   mode;
    check_in_t    check_in;
    config_word_t rd_word, wr_word;
    int           err_count = 0, compares = 0, writes = 0, cycles = 0;
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    tmcfg_tester u_tester (.CLK_SYS(clk), .rb_in(rb), .step(step), .data(data),
        .sclk(sclk), .strobe(strobe));
    test_mode_serial_config #(.STANDBY_CYC(SB_CYC)) dut (
        .CLK_SYS(clk), .RST(rst), .MODE_STEP_PIN(step), .MODE_DATA_PIN(data),
        .SHIFT_CLK_PIN(sclk), .COMMIT_STROBE_PIN(strobe), .CHECK_IN(check_in),
        .NVM_READ_WORD(rd_word), .CHECK_RESULT_OUT(result), .INDICATOR_LAMP_OUT(lamp),
        .SOUNDER_OUT(sounder), .BATTERY_TEST_EN(bat_en), .NVM_WRITE(nvm_wr),
        .NVM_WRITE_WORD(wr_word), .READBACK_OUT(rb), .SERIAL_MODE(serial),
        .TEST_MODE(mode));
    task automatic check(input logic [34:0] seen, input logic [34:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compares=%0d errors=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    // Count write pulses; a hang is cut short well past the expected run
    always @(posedge clk) begin
        cycles++;
        if (nvm_wr === 1'b1) writes++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic do_reset();
        u_tester.idle_pins();
        rst = 1'b1;
        u_tester.tick(4);
        rst = 1'b0;
        u_tester.tick(2);
    endtask : do_reset
    initial begin
        rst = 1'b1;
        check_in = '0;
        rd_word = RB_WORD;
        do_reset();
        // Sounder check: data falling turns it on for good
        u_tester.enter_mode(3);
        check(mode, MODE_SOUNDER);
        check(sounder, 1'b0);
        u_tester.set_data(1'b0);
        check(sounder, 1'b1);
        // Standby check reports smoke only after the long low
        do_reset();
        check_in = 5'h10;
        u_tester.enter_mode(12);
        u_tester.set_data(1'b0);
        u_tester.tick(SB_CYC / 2);
        check(result, 1'b0);
        u_tester.tick(SB_CYC);
        check(result, 1'b1);
        // Hysteresis, quiet and bias checks each follow their own input bit
        for (int m = 13; m <= 15; m++) begin
            do_reset();
            check_in = 5'h01 << (16 - m);
            u_tester.enter_mode(m);
            check(result, 1'b0);
            u_tester.set_data(1'b0);
            check(result, 1'b1);
        end
        // Battery check: strobe lights the lamp and reports low battery
        do_reset();
        check_in = 5'h01;
        u_tester.enter_mode(17);
        check({lamp, bat_en}, 2'b00);
        u_tester.strobe_pulse();
        check({lamp, bat_en, result}, 3'b111);
        // Full word in mode 18 after mode 17 shift edges: readback, single write and field positions checked
        do_reset();
        u_tester.enter_mode(17);
        u_tester.shift(35'h7_FFFF_FFFF, 3);
        u_tester.steps(1);
        check({serial, mode}, {1'b1, MODE_SERIAL});
        u_tester.shift(WR_WORD, WORD_BITS);
        check(u_tester.rb_bits & MASK, RB_WORD & MASK);
        u_tester.strobe_pulse();
        check(writes, 1);
        check(wr_word & MASK, WR_WORD & MASK);
        check(wr_word.battery_trip_field, WR_WORD[16:15]);
        check(wr_word.memory_timeout_sel, WR_WORD[7:6]);
        check(wr_word.quiet_disable_n, WR_WORD[1]);
        // Lock mode with data low and a strobe pulse writes nothing here
        do_reset();
        u_tester.enter_mode(19);
        check(mode, MODE_LOCK);
        u_tester.set_data(1'b0);
        u_tester.strobe_pulse();
        check(writes, 1);
        // Short word refused; leaked mode 17 edges would fill it and let it write
        do_reset();
        rd_word = WR_WORD;
        u_tester.enter_mode(17);
        u_tester.shift(35'h7_FFFF_FFFF, 3);
        u_tester.steps(1);
        u_tester.shift(WR_WORD, WORD_BITS - 1);
        check(u_tester.rb_bits[33:0] & MASK[33:0], WR_WORD[33:0] & MASK[33:0]);
        u_tester.strobe_pulse();
        u_tester.tick(10);
        check(writes, 1);
        report_and_stop();
    end
endmodule : test_mode_serial_config_tb
